// file: common/wwdt_pkg.sv
// Constants, types and register map of the windowed watchdog
package wwdt_pkg;
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam int PS_W = 18;
    localparam int CNT_W = 5;
    localparam logic [4:0] PS_MAX = 5'h12;
    localparam logic [4:0] PS_DEFAULT = 5'h0b;
    localparam logic [4:0] PS_FROM_REG = 5'h1f;
    localparam logic [2:0] CS_FROM_REG = 3'h7;
    localparam logic [2:0] WIN_FROM_REG = 3'h7;
    localparam logic [2:0] WIN_FULL = 3'h7;
    localparam logic [2:0] CS_LF = 3'h0;
    localparam logic [2:0] CS_MF = 3'h1;
    localparam logic [2:0] CS_SECONDARY_OSC = 3'h2;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SW = 2'h1;
    localparam logic [1:0] MODE_NOSLEEP = 2'h2;
    localparam logic [1:0] MODE_ON = 2'h3;
    localparam logic [CNT_W-1:0] CNT_TOP = 5'h1f;
    localparam int CTRL0_PS_LSB = 1;
    localparam int CTRL1_CS_LSB = 4;
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] clkSel;
        logic [2:0] winSize;
        logic [4:0] presSel;
    } wwdt_cfg_t;
    typedef struct packed {
        logic lf;
        logic mf;
        logic secondary_osc;
    } wwdt_ticks_t;
    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } wwdt_state_t;
endpackage

// file: rtl/wwdt_top.sv
// Windowed watchdog with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module wwdt_top import wwdt_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Configuration and core events
    input var wwdt_cfg_t cfg,
    input var wwdt_ticks_t ticks,
    input wire logic clearInstr,
    input wire logic sleepMode,
    input wire logic ostRunning,
    // Reset and wake requests
    output logic wdtResetReq,
    output logic wdtWakeReq
);
    wwdt_state_t state_q;
    logic [4:0] psSel_q;
    logic swEn_q;
    logic [2:0] clkSel_q;
    logic [2:0] win_q;
    logic winOkN_q;
    logic timeoutN_q;
    logic armed_q;
    logic sleep_q;
    logic [PS_W-1:0] psCnt_q;
    logic [CNT_W-1:0] cnt_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;
    logic resetReq_q;
    logic wakeReq_q;
    logic readyOut_q;
    logic respErr_q;
    logic [4:0] psEff;
    logic [2:0] csEff;
    logic [2:0] winEff;
    logic active;
    logic tick;
    logic [PS_W-1:0] psMask;
    logic tapHit;
    logic timeout;
    logic closed;
    logic windowed;
    logic violation;
    logic event_w;
    logic cntClear;
    logic addrPh;
    logic rdCtrl0;
    logic wrCtrl;
    logic [7:0] rdVal;

    // Effective settings: registers only steer when configuration defers
    assign psEff = (cfg.presSel == PS_FROM_REG) ? psSel_q : cfg.presSel;
    assign csEff = (cfg.clkSel == CS_FROM_REG) ? clkSel_q : cfg.clkSel;
    assign winEff = (cfg.winSize == WIN_FROM_REG) ? win_q : cfg.winSize;
    assign windowed = (winEff != WIN_FULL);

    always_comb begin
        case (cfg.mode)
            MODE_ON: active = 1'b1;
            MODE_NOSLEEP: active = !sleepMode;
            MODE_SW: active = swEn_q;
            default: active = 1'b0;
        endcase
    end

    always_comb begin
        case (csEff)
            CS_LF: tick = ticks.lf;
            CS_MF: tick = ticks.mf;
            CS_SECONDARY_OSC: tick = ticks.secondary_osc;
            default: tick = 1'b0;
        endcase
    end

    // Reserved prescale codes fall back to the shortest tap
    genvar gi;
    generate
        for (gi = 0; gi < PS_W; gi++) begin : g_mask
            assign psMask[gi] = (psEff <= PS_MAX) && (5'(gi) < psEff);
        end
    endgenerate

    assign tapHit = tick && ((psCnt_q & psMask) == psMask);
    // A watchdog that was just disabled must not fire on its last tick
    assign timeout = active && tapHit && (cnt_q == CNT_TOP) && (state_q == ST_RUN);
    assign closed = windowed && ({1'b0, cnt_q[CNT_W-1:CNT_W-3]} < (4'd7 - {1'b0, winEff}));
    assign violation = clearInstr && active && windowed && (closed || !armed_q);
    assign event_w = timeout || (violation && !sleepMode);

    // AHB-Lite decode
    assign addrPh = hsel && htrans[1] && hready;
    assign rdCtrl0 = addrPh && !hwrite && (haddr[7:0] == ADDR_CTRL0);
    assign wrCtrl = wrPend_q && ((wrAddr_q == ADDR_CTRL0) || (wrAddr_q == ADDR_CTRL1));

    assign cntClear = !active || clearInstr || (sleepMode != sleep_q) || ostRunning
        || wrCtrl || event_w;

    always_comb begin
        case (haddr[7:0])
            ADDR_CTRL0: rdVal = {2'b00, psSel_q, swEn_q};
            ADDR_CTRL1: rdVal = {1'b0, clkSel_q, 1'b0, win_q};
            ADDR_STAT: rdVal = {5'b00000, armed_q, timeoutN_q, winOkN_q};
            default: rdVal = 8'h00;
        endcase
    end

    // Reset values that depend on configuration are caught after release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_INIT;
        end else begin
            case (state_q)
                ST_INIT: state_q <= ST_RUN;
                ST_RUN: state_q <= event_w ? ST_HOLD : ST_RUN;
                ST_HOLD: state_q <= ST_RUN;
                default: state_q <= ST_INIT;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            psSel_q <= PS_DEFAULT;
            swEn_q <= 1'b0;
            clkSel_q <= CS_LF;
            win_q <= WIN_FULL;
        end else if (state_q == ST_INIT) begin
            psSel_q <= (cfg.presSel == PS_FROM_REG) ? PS_DEFAULT : cfg.presSel;
            clkSel_q <= (cfg.clkSel == CS_FROM_REG) ? CS_LF : cfg.clkSel;
            win_q <= cfg.winSize;
        end else if (wrPend_q && wrAddr_q == ADDR_CTRL0) begin
            swEn_q <= hwdata[0];
            if (cfg.presSel == PS_FROM_REG) begin
                psSel_q <= hwdata[CTRL0_PS_LSB +: 5];
            end
        end else if (wrPend_q && wrAddr_q == ADDR_CTRL1) begin
            if (cfg.clkSel == CS_FROM_REG) begin
                clkSel_q <= hwdata[CTRL1_CS_LSB +: 3];
            end
            if (cfg.winSize == WIN_FROM_REG) begin
                win_q <= hwdata[2:0];
            end
        end
    end

    // Hardware clearing wins over a firmware set in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            winOkN_q <= 1'b1;
            timeoutN_q <= 1'b1;
        end else begin
            if (violation && !sleepMode) begin
                winOkN_q <= 1'b0;
            end else if (wrPend_q && wrAddr_q == ADDR_STAT && hwdata[0]) begin
                winOkN_q <= 1'b1;
            end
            if (timeout) begin
                timeoutN_q <= 1'b0;
            end else if (wrPend_q && wrAddr_q == ADDR_STAT && hwdata[1]) begin
                timeoutN_q <= 1'b1;
            end
        end
    end

    // Any clear consumes the arming; a CTRL0 read in the same cycle arms the next clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (rdCtrl0) begin
            armed_q <= 1'b1;
        end else if (clearInstr || event_w) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleepMode;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            psCnt_q <= '0;
            cnt_q <= '0;
        end else if (cntClear || state_q != ST_RUN) begin
            psCnt_q <= '0;
            cnt_q <= '0;
        end else if (tick) begin
            psCnt_q <= tapHit ? '0 : psCnt_q + 1'b1;
            cnt_q <= tapHit ? cnt_q + 1'b1 : cnt_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resetReq_q <= 1'b0;
            wakeReq_q <= 1'b0;
        end else begin
            resetReq_q <= event_w && !sleepMode;
            wakeReq_q <= timeout && sleepMode;
        end
    end

    // Zero wait states: read data is latched at the address phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            readyOut_q <= 1'b1;
            respErr_q <= 1'b0;
        end else begin
            readyOut_q <= 1'b1;
            respErr_q <= 1'b0;
            wrPend_q <= addrPh && hwrite;
            if (addrPh) begin
                wrAddr_q <= haddr[7:0];
            end
            if (addrPh && !hwrite) begin
                hrdata_q <= {24'h00_0000, rdVal};
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = readyOut_q;
    assign hresp = respErr_q;
    assign wdtResetReq = resetReq_q;
    assign wdtWakeReq = wakeReq_q;

    property p_timeout_reset;
        @(posedge clock) disable iff (!rst_n)
        (timeout && !sleepMode) |=> wdtResetReq;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on time-out");

    property p_sleep_wake;
        @(posedge clock) disable iff (!rst_n)
        (timeout && sleepMode) |=> (wdtWakeReq && !wdtResetReq);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep time-out misbehaved");

    property p_mode_off;
        @(posedge clock) disable iff (!rst_n)
        (cfg.mode == MODE_OFF) |=> (cnt_q == '0 && psCnt_q == '0);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("counting while off");

    property p_nosleep;
        @(posedge clock) disable iff (!rst_n)
        (cfg.mode == MODE_NOSLEEP && sleepMode) |=> (cnt_q == '0 && !wdtResetReq && !wdtWakeReq);
    endproperty
    a_nosleep: assert property (p_nosleep) else $error("active in sleep");

    property p_unarmed;
        @(posedge clock) disable iff (!rst_n)
        (clearInstr && active && windowed && !armed_q && !sleepMode) |=> (wdtResetReq && !winOkN_q);
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("unarmed clear accepted");

    property p_closed;
        @(posedge clock) disable iff (!rst_n)
        (clearInstr && active && closed && !sleepMode) |=> ##[0:1] !winOkN_q;
    endproperty
    a_closed: assert property (p_closed) else $error("closed-window clear accepted");

    property p_write_clear;
        @(posedge clock) disable iff (!rst_n)
        wrCtrl |=> (cnt_q == '0);
    endproperty
    a_write_clear: assert property (p_write_clear) else $error("write kept count");

    property p_pulse;
        @(posedge clock) disable iff (!rst_n)
        wdtResetReq |-> (cnt_q == '0) ##1 (!wdtResetReq && cnt_q == '0);
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset request not single");

    property p_full_window;
        @(posedge clock) disable iff (!rst_n)
        (winEff == WIN_FULL && clearInstr) |-> !violation;
    endproperty
    a_full_window: assert property (p_full_window) else $error("clear refused in full window");

    property p_ost_clear;
        @(posedge clock) disable iff (!rst_n)
        ostRunning |=> (cnt_q == '0 && psCnt_q == '0);
    endproperty
    a_ost_clear: assert property (p_ost_clear) else $error("count ran during start-up");

    property p_timeout_flag;
        @(posedge clock) disable iff (!rst_n)
        timeout |=> !timeoutN_q;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("time-out flag kept");

    property p_violation_flag;
        @(posedge clock) disable iff (!rst_n)
        (violation && !sleepMode) |=> !winOkN_q;
    endproperty
    a_violation_flag: assert property (p_violation_flag) else $error("violation flag kept");
endmodule
`default_nettype wire

// file: tb/wwdt_cpu_model.sv
// CPU core model: AHB-Lite master and clear-watchdog pulses
`timescale 1ns/100ps
`default_nettype none
module wwdt_cpu_model (
    // Clock and bus answer
    input wire logic clock,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // Bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Core event
    output logic clearInstr
);
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, clearInstr} = 72'h0;
    end
    // Each phase is held until ready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        // Released data lines must not keep a stale value
        hwdata <= ~hwdata;
    endtask
    task automatic clr();
        @(posedge clock);
        clearInstr <= 1'b1;
        @(posedge clock);
        clearInstr <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the windowed watchdog
`timescale 1ns/100ps
`default_nettype none
module tb_top import wwdt_pkg::*; ;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sleepMode = 1'b0;
    logic ostRunning = 1'b0;
    wwdt_cfg_t cfg = '0;
    wwdt_ticks_t ticks = '0;
    logic hsel, hwrite, hresp, hreadyout, clearInstr, wdtResetReq, wdtWakeReq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [2:0] wl [3] = '{3'h3, 3'h0, 3'h7};
    int fails = 0;
    int n_compared = 0;
    int tc = 0;
    always #5 clock = ~clock;
    // Oscillator ticks at one in two, three and four cycles
    always @(posedge clock) begin
        tc <= tc + 1;
        ticks <= {tc % 2 == 0, tc % 3 == 0, tc % 4 == 0};
    end
    wwdt_top u_wwdt_top (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cfg(cfg), .ticks(ticks), .clearInstr(clearInstr), .sleepMode(sleepMode),
        .ostRunning(ostRunning), .wdtResetReq(wdtResetReq), .wdtWakeReq(wdtWakeReq));
    wwdt_cpu_model u_wwdt_cpu_model (.clock(clock), .hreadyout(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .clearInstr(clearInstr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        u_wwdt_cpu_model.xfer(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp);
        chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_wwdt_cpu_model.xfer(1'b1, a, d, rd);
    endtask
    task automatic rst(input logic [1:0] m, input logic [2:0] c, input logic [2:0] w,
        input logic [4:0] p);
        @(posedge clock);
        rst_n <= 1'b0;
        sleepMode <= 1'b0;
        cfg <= {m, c, w, p};
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    // Request must come within lo..hi cycles and last one cycle
    task automatic evt(input logic isRst, input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (wdtResetReq !== 1'b1 && wdtWakeReq !== 1'b1 && n < hi) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk({31'h0, n >= lo && n < hi}, 32'h0000_0001);
        chk({30'h0, wdtResetReq, wdtWakeReq}, {30'h0, isRst, !isRst});
        @(posedge clock);
        #1;
        chk({31'h0, wdtResetReq | wdtWakeReq}, 32'h0000_0000);
        @(posedge clock);
    endtask
    task automatic quiet(input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            @(posedge clock);
            #1;
            hit |= wdtResetReq | wdtWakeReq;
        end
        chk({31'h0, hit}, 32'h0000_0000);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        rst(MODE_OFF, CS_FROM_REG, 3'h5, PS_FROM_REG);
        rdc(ADDR_STAT, 32'h0000_0003);
        rdc(ADDR_CTRL0, 32'h0000_0016);
        rdc(ADDR_CTRL1, 32'h0000_0005);
        wr(ADDR_CTRL1, 32'h0000_0022);
        rdc(ADDR_CTRL1, 32'h0000_0025);
        rdc(8'h0c, 32'h0000_0000);
        wr(ADDR_CTRL0, 32'h0000_0001);
        rdc(ADDR_CTRL0, 32'h0000_0001);
        quiet(150);
        $display("Reset values and disabled mode done");
        for (int c = 0; c < 4; c++) begin
            rst(MODE_ON, c[2:0], WIN_FULL, 5'h00);
            if (c == 3) quiet(150);
            else evt(1'b1, 32 * (c + 2) - 8, 32 * (c + 2) + 16);
        end
        $display("Clock select done");
        rst(MODE_ON, CS_LF, WIN_FULL, PS_FROM_REG);
        wr(ADDR_CTRL0, 32'h0000_0026);
        evt(1'b1, 56, 80);
        rdc(ADDR_STAT, 32'h0000_0001);
        wr(ADDR_STAT, 32'h0000_0002);
        rdc(ADDR_STAT, 32'h0000_0003);
        ostRunning <= 1'b1;
        quiet(150);
        @(posedge clock);
        ostRunning <= 1'b0;
        evt(1'b1, 56, 80);
        // Window stays full, so these clears are always valid
        for (int i = 0; i < 6; i++) begin
            quiet(40);
            if (i[0]) wr(ADDR_CTRL1, 32'h0000_0007);
            else u_wwdt_cpu_model.clr();
        end
        quiet(40);
        $display("Time-out and clearing done");
        rst(MODE_NOSLEEP, CS_LF, WIN_FULL, 5'h00);
        sleepMode <= 1'b1;
        quiet(150);
        rst(MODE_ON, CS_LF, WIN_FULL, 5'h00);
        sleepMode <= 1'b1;
        evt(1'b0, 56, 80);
        rst(MODE_SW, CS_LF, WIN_FULL, 5'h00);
        quiet(150);
        wr(ADDR_CTRL0, 32'h0000_0001);
        evt(1'b1, 56, 80);
        $display("Modes done");
        rst(MODE_ON, CS_LF, 3'h3, 5'h00);
        u_wwdt_cpu_model.clr();
        evt(1'b1, 0, 4);
        rdc(ADDR_STAT, 32'h0000_0002);
        wr(ADDR_STAT, 32'h0000_0001);
        rdc(ADDR_STAT, 32'h0000_0003);
        // Clear near 23 of 32 ticks: open for half, closed for seven eighths
        for (int i = 0; i < 3; i++) begin
            rst(MODE_ON, CS_LF, wl[i], 5'h00);
            if (i == 2) wr(ADDR_CTRL1, 32'h0000_0000);
            quiet(44);
            rdc(ADDR_CTRL0, 32'h0000_0000);
            u_wwdt_cpu_model.clr();
            if (i == 0) quiet(40);
            else evt(1'b1, 0, 4);
        end
        $display("Window done");
        print_verdict();
    end
endmodule
`default_nettype wire
